// ### rtl/twm_cfg.svh
`ifndef TWM_CFG_SVH
`define TWM_CFG_SVH

// register byte addresses
`define TWM_ADDR_CFG        24'hFFFF20
`define TWM_ADDR_PRE        24'hFFFF22
`define TWM_ADDR_T0         24'hFFFF24
`define TWM_ADDR_CSR        24'hFFFF26
`define TWM_ADDR_RLD        24'hFFFF28
`define TWM_ADDR_MATCH      24'hFFFF2A

// watchdog_config field positions
`define TWM_CFG_LOCK_CFG    0
`define TWM_CFG_LOCK_PRE    1
`define TWM_CFG_LOCK_T0     2
`define TWM_CFG_LOCK_RLD    3
`define TWM_CFG_CLK_TICK    4
`define TWM_CFG_MATCH_EN    5
`define TWM_CFG_LOCK_MASK   6'h0F

// timer0_control_status field positions
`define TWM_CSR_RESTART     0
`define TWM_CSR_TC          1
`define TWM_CSR_INTE        2

// reset values
`define TWM_CFG_RST         6'h00
`define TWM_DIV_RST         3'h0
`define TWM_PRESET_RST      16'hFFFF
`define TWM_RELOAD_RST      8'h0F
`define TWM_WD_CNT_RST      8'h00

// constants of behaviour
`define TWM_SERVICE_KEY     8'h5C
`define TWM_DIV_MAX         3'h5
`define TWM_MASK_MAX        5'h1F
`define TWM_LOCKED_READ     16'h0000
`define TWM_ONE8            8'h01
`define TWM_ONE5            5'h01
`define TWM_ONE16           16'h0001

`endif

// ### rtl/twm_pkg.sv
package twm_pkg;

    // operating mode of the surrounding device
    typedef enum logic [1:0] {
        mode_active = 2'b00,
        mode_save   = 2'b01,
        mode_idle   = 2'b10,
        mode_halt   = 2'b11
    } twm_mode_t;

    // whole state of the block
    typedef struct packed {
        logic        lsc_prev;
        logic [5:0]  cfg;
        logic [2:0]  div;
        logic [4:0]  presc_cnt;
        logic        tick;
        logic [15:0] t0_preset;
        logic [15:0] t0_cnt;
        logic        t0_uf;
        logic        restart;
        logic        tc;
        logic        inte;
        logic [7:0]  wd_reload;
        logic [7:0]  wd_cnt;
        logic        wd_run;
        logic        wd_serviced;
        logic        wd_error;
        logic [15:0] rd_data;
    } twm_state_t;

endpackage

// ### rtl/twm_watchdog.sv
`timescale 1ns/100ps
// How it works
// - watchdog is an 8-bit down counter stepping on its selected clock
// - after reset the watchdog is stopped and raises no error
// - writing reload count or service match starts it from the reload value
// - once started nothing but device reset stops the watchdog
// - config bit 4 picks timer0 underflow (0) or prescaled tick (1)
// - match disabled: reload writes reload counter, match writes are ignored
// - match enabled: writing 5Ch reloads counter from stored reload count
// - late service raises watchdog error
// - service more than once per watchdog clock raises error
// - match enabled: any match value other than 5Ch raises error
// - any watchdog error requests a reset of the whole device
// - locked register ignores writes and reads return zero
// - lock bits are sticky until device reset
// - lock bits 0..3 guard config, prescaler, timer0 pair, reload count
// - save and idle modes keep all counters running
// - outside active mode only the service match register is reachable
// - halt mode freezes every counter, resuming where it stopped
// - 3-bit divider gives divisors 1,2,4,8,16,32; other codes reserved
// - timer0 preset resets to FFFFh and reloads timer0 on underflow
// - reset clears config: unlocked, reload servicing, underflow clock
// - underflow pulse lasts exactly one prescaled tick period for any nonzero preset
// - two match writes within one watchdog clock raise error
// - reload count resets to 0Fh
`include "twm_cfg.svh"

module twm_watchdog (
    input  wire logic                sys_clk,
    input  wire logic                reset,
    input  wire twm_pkg::twm_mode_t  power_mode,
    input  wire logic                low_speed_clock,
    input  wire logic [23:0]         addr,
    input  wire logic [15:0]         wr_data,
    input  wire logic                wr_strobe,
    input  wire logic                rd_strobe,
    output logic      [15:0]         rd_data,
    output logic                     prescaled_tick,
    output logic                     timer0_underflow_pulse,
    output logic                     wd_running,
    output logic      [7:0]          wd_count,
    output logic                     wd_error_reset
);
    import twm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // reset image and helpers

    localparam twm_state_t STATE_RST = '{
        lsc_prev:    1'b0,
        cfg:         `TWM_CFG_RST,
        div:         `TWM_DIV_RST,
        presc_cnt:   5'h00,
        tick:        1'b0,
        t0_preset:   `TWM_PRESET_RST,
        t0_cnt:      `TWM_PRESET_RST,
        t0_uf:       1'b0,
        restart:     1'b0,
        tc:          1'b0,
        inte:        1'b0,
        wd_reload:   `TWM_RELOAD_RST,
        wd_cnt:      `TWM_WD_CNT_RST,
        wd_run:      1'b0,
        wd_serviced: 1'b0,
        wd_error:    1'b0,
        rd_data:     16'h0000
    };

    // low bits of the prescaler that must all be set for a tick
    function automatic logic [4:0] div_mask(input logic [2:0] code);
        logic [4:0] m;
        m = `TWM_MASK_MAX;
        if (code <= `TWM_DIV_MAX) begin
            m = 5'((`TWM_ONE5 << code) - `TWM_ONE5);
        end
        return m;
    endfunction

    // register reachable: right mode and its lock bit clear
    function automatic logic reg_open(input logic act, input logic lock);
        return act & ~lock;
    endfunction

    twm_state_t s;
    twm_state_t n;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic        active;
        logic        slow_edge;
        logic        tick_now;
        logic        uf_rise;
        logic        wd_edge;
        logic        err;
        logic        service;
        logic [7:0]  service_val;
        logic [4:0]  mask;
        active      = 1'b0;
        slow_edge   = 1'b0;
        tick_now    = 1'b0;
        uf_rise     = 1'b0;
        wd_edge     = 1'b0;
        err         = 1'b0;
        service     = 1'b0;
        service_val = s.wd_reload;
        mask        = div_mask(s.div);
        n           = s;
        n.tick      = 1'b0;
        n.rd_data   = 16'h0000;

        active = (power_mode == mode_active);
        // halt freezes everything; save and idle run on as in active
        n.lsc_prev = low_speed_clock;
        slow_edge  = low_speed_clock & ~s.lsc_prev;
        if (power_mode == mode_halt) begin
            slow_edge = 1'b0;
        end

        // prescaler: a free count, tick when the selected low bits wrap
        if (slow_edge) begin
            n.presc_cnt = 5'(s.presc_cnt + `TWM_ONE5);
            tick_now    = ((s.presc_cnt & mask) == mask);
        end
        n.tick = tick_now;

        // timer0: holds zero for one tick period, then reloads
        if (tick_now) begin
            if (s.restart) begin
                n.t0_cnt  = s.t0_preset;
                n.restart = 1'b0;
            end else if (s.t0_cnt == 16'h0000) begin
                n.t0_cnt = s.t0_preset;
            end else begin
                n.t0_cnt = 16'(s.t0_cnt - `TWM_ONE16);
            end
            n.t0_uf = (n.t0_cnt == 16'h0000);
            uf_rise = n.t0_uf;
        end

        // watchdog clock source
        if (s.cfg[`TWM_CFG_CLK_TICK]) begin
            wd_edge = tick_now;
        end else begin
            wd_edge = uf_rise;
        end

        // watchdog counting, only once started
        if (s.wd_run && wd_edge) begin
            n.wd_serviced = 1'b0;
            if (s.wd_cnt != 8'h00) begin
                n.wd_cnt = 8'(s.wd_cnt - `TWM_ONE8);
            end
            // reaching zero before a service counts as late
            if (s.wd_cnt <= `TWM_ONE8) begin
                err = 1'b1;
            end
        end

        ////////////////////////////////////////////////////////////////////
        // register writes

        if (wr_strobe) begin
            case (addr)
                `TWM_ADDR_CFG: begin
                    if (reg_open(active, s.cfg[`TWM_CFG_LOCK_CFG])) begin
                        // lock bits only ever gain ones
                        n.cfg = wr_data[5:0] | (s.cfg & `TWM_CFG_LOCK_MASK);
                    end
                end
                `TWM_ADDR_PRE: begin
                    if (reg_open(active, s.cfg[`TWM_CFG_LOCK_PRE])) begin
                        n.div = wr_data[2:0];
                    end
                end
                `TWM_ADDR_T0: begin
                    // new preset is taken at the next reload only
                    if (reg_open(active, s.cfg[`TWM_CFG_LOCK_T0])) begin
                        n.t0_preset = wr_data;
                    end
                end
                `TWM_ADDR_CSR: begin
                    if (reg_open(active, s.cfg[`TWM_CFG_LOCK_T0])) begin
                        if (wr_data[`TWM_CSR_RESTART]) begin
                            n.restart = 1'b1;
                        end
                        n.inte = wr_data[`TWM_CSR_INTE];
                    end
                end
                `TWM_ADDR_RLD: begin
                    if (reg_open(active, s.cfg[`TWM_CFG_LOCK_RLD])) begin
                        n.wd_reload = wr_data[7:0];
                        if (!s.wd_run) begin
                            service     = 1'b1;
                            service_val = wr_data[7:0];
                        end else if (!s.cfg[`TWM_CFG_MATCH_EN]) begin
                            service     = 1'b1;
                            service_val = wr_data[7:0];
                        end
                    end
                end
                `TWM_ADDR_MATCH: begin
                    // reachable in every mode, so save mode can still service
                    if (s.cfg[`TWM_CFG_MATCH_EN]) begin
                        if (wr_data[7:0] != `TWM_SERVICE_KEY) begin
                            err = 1'b1;
                        end else begin
                            service     = 1'b1;
                            service_val = s.wd_reload;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // a service is refused if one already fell in this watchdog clock
        if (service) begin
            if (s.wd_run && s.wd_serviced && !wd_edge) begin
                err = 1'b1;
            end else begin
                n.wd_cnt      = service_val;
                n.wd_run      = 1'b1;
                n.wd_serviced = 1'b1;
            end
        end

        ////////////////////////////////////////////////////////////////////
        // register reads, data stand the cycle after

        if (rd_strobe) begin
            case (addr)
                `TWM_ADDR_CFG: begin
                    if (reg_open(active, s.cfg[`TWM_CFG_LOCK_CFG])) begin
                        n.rd_data = {10'h000, s.cfg};
                    end else begin
                        n.rd_data = `TWM_LOCKED_READ;
                    end
                end
                `TWM_ADDR_PRE: begin
                    if (reg_open(active, s.cfg[`TWM_CFG_LOCK_PRE])) begin
                        n.rd_data = {13'h0, s.div};
                    end else begin
                        n.rd_data = `TWM_LOCKED_READ;
                    end
                end
                `TWM_ADDR_T0: begin
                    if (reg_open(active, s.cfg[`TWM_CFG_LOCK_T0])) begin
                        n.rd_data = s.t0_preset;
                    end else begin
                        n.rd_data = `TWM_LOCKED_READ;
                    end
                end
                `TWM_ADDR_CSR: begin
                    if (reg_open(active, s.cfg[`TWM_CFG_LOCK_T0])) begin
                        n.rd_data[`TWM_CSR_RESTART] = s.restart;
                        n.rd_data[`TWM_CSR_TC]      = s.tc;
                        n.rd_data[`TWM_CSR_INTE]    = s.inte;
                        n.tc                        = 1'b0;
                    end else begin
                        n.rd_data = `TWM_LOCKED_READ;
                    end
                end
                default: begin
                    // write-only and unmapped addresses read zero
                    n.rd_data = 16'h0000;
                end
            endcase
        end

        // terminal count: a set in the clearing cycle wins
        if (uf_rise) begin
            n.tc = 1'b1;
        end

        // error held until the device reset it asks for arrives
        n.wd_error = s.wd_error | err;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s <= STATE_RST;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register

    assign rd_data                = s.rd_data;
    assign prescaled_tick         = s.tick;
    assign timer0_underflow_pulse = s.t0_uf;
    assign wd_running             = s.wd_run;
    assign wd_count               = s.wd_cnt;
    assign wd_error_reset         = s.wd_error;

endmodule

// ### verification/test_watchdog_lock_prescale_unit.sv
`timescale 1ns/100ps
`include "twm_cfg.svh"
module test_watchdog_lock_prescale_unit;
    import twm_pkg::*;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    twm_mode_t   power_mode = mode_active;
    logic        low_speed_clock = 1'b0;
    logic [23:0] addr = 24'h000000;
    logic [15:0] wr_data = 16'h0000;
    logic        wr_strobe = 1'b0;
    logic        rd_strobe = 1'b0;
    logic [15:0] rd_data;
    logic        prescaled_tick;
    logic        timer0_underflow_pulse;
    logic        wd_running;
    logic [7:0]  wd_count;
    logic        wd_error_reset;
    logic [15:0] got;
    int          fail_count = 0;
    int          n_compared = 0;
    int          n_tick = 0;
    twm_watchdog dut_u (.sys_clk, .reset, .power_mode, .low_speed_clock, .addr, .wr_data,
        .wr_strobe, .rd_strobe, .rd_data, .prescaled_tick, .timer0_underflow_pulse,
        .wd_running, .wd_count, .wd_error_reset);
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (prescaled_tick === 1'b1) n_tick <= n_tick + 1;
    ////////////////////////////////////////
    function automatic logic [15:0] st();
        return {6'h00, wd_running, wd_error_reset, wd_count};
    endfunction
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] act);
        n_compared++;
        if (act !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, act);
        end
    endtask
    task automatic do_reset;
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_strobe <= 1'b1;
        @(posedge sys_clk);
        wr_strobe <= 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic rd(input logic [23:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge sys_clk);
        rd_strobe <= 1'b0;
        @(negedge sys_clk);
        got = rd_data;
    endtask
    // slow edges five system cycles apart, well above the two-cycle minimum
    task automatic slow(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            low_speed_clock <= 1'b1;
            repeat (2) @(posedge sys_clk);
            low_speed_clock <= 1'b0;
            repeat (2) @(posedge sys_clk);
        end
        @(negedge sys_clk);
    endtask
    task automatic mode(input twm_mode_t m);
        @(posedge sys_clk);
        power_mode <= m;
    endtask
    ////////////////////////////////////////
    task automatic t_reset;
        rd(`TWM_ADDR_CFG);
        chk("config", 16'h0000, got);
        rd(`TWM_ADDR_T0);
        chk("preset", 16'hFFFF, got);
        wr(`TWM_ADDR_CFG, 16'h0010);
        slow(3);
        chk("idle", 16'h0000, st());
    endtask
    // reserved codes 6 and 7 fall back to divide by 32
    task automatic t_div;
        int base;
        for (int k = 0; k < 8; k++) begin
            wr(`TWM_ADDR_PRE, 16'(k));
            base = n_tick;
            slow(64);
            chk("ticks", 16'(64 >> ((k > 5) ? 5 : k)), 16'(n_tick - base));
        end
    endtask
    task automatic t_reload;
        wr(`TWM_ADDR_PRE, 16'h0000);
        wr(`TWM_ADDR_RLD, 16'h0003);
        chk("start", 16'h0203, st());
        slow(1);
        chk("step", 16'h0202, st());
        wr(`TWM_ADDR_MATCH, 16'h0011);
        chk("match off", 16'h0202, st());
        wr(`TWM_ADDR_RLD, 16'h0005);
        chk("service", 16'h0205, st());
        wr(`TWM_ADDR_RLD, 16'h0005);
        chk("too often", 16'h0305, st());
        do_reset;
        chk("after reset", 16'h0000, st());
        wr(`TWM_ADDR_CFG, 16'h0010);
        wr(`TWM_ADDR_RLD, 16'h0002);
        slow(1);
        chk("in time", 16'h0201, st());
        slow(1);
        chk("late", 16'h0300, st());
    endtask
    task automatic t_match;
        do_reset;
        wr(`TWM_ADDR_CFG, 16'h0030);
        wr(`TWM_ADDR_MATCH, 16'h005C);
        chk("match start", 16'h020F, st());
        slow(1);
        wr(`TWM_ADDR_MATCH, 16'h005C);
        chk("match service", 16'h020F, st());
        wr(`TWM_ADDR_MATCH, 16'h005C);
        chk("double match", 16'h030F, st());
        do_reset;
        wr(`TWM_ADDR_CFG, 16'h0030);
        wr(`TWM_ADDR_MATCH, 16'h005C);
        slow(1);
        wr(`TWM_ADDR_MATCH, 16'h005B);
        chk("bad key", 16'h030E, st());
    endtask
    task automatic t_lock;
        do_reset;
        wr(`TWM_ADDR_PRE, 16'h0003);
        wr(`TWM_ADDR_T0, 16'h1234);
        rd(`TWM_ADDR_T0);
        chk("preset", 16'h1234, got);
        rd(`TWM_ADDR_PRE);
        chk("divider", 16'h0003, got);
        wr(`TWM_ADDR_RLD, 16'h0009);
        wr(`TWM_ADDR_CFG, 16'h0008);
        wr(`TWM_ADDR_RLD, 16'h0007);
        chk("locked reload", 16'h0209, st());
        wr(`TWM_ADDR_CFG, 16'h0000);
        rd(`TWM_ADDR_CFG);
        chk("sticky", 16'h0008, got);
        wr(`TWM_ADDR_CFG, 16'h0007);
        rd(`TWM_ADDR_CFG);
        chk("cfg locked", 16'h0000, got);
        rd(`TWM_ADDR_PRE);
        chk("pre locked", 16'h0000, got);
        rd(`TWM_ADDR_T0);
        chk("t0 locked", 16'h0000, got);
    endtask
    task automatic t_modes;
        do_reset;
        wr(`TWM_ADDR_CFG, 16'h0010);
        mode(mode_save);
        rd(`TWM_ADDR_CFG);
        chk("save read", 16'h0000, got);
        wr(`TWM_ADDR_RLD, 16'h0003);
        chk("save write", 16'h0000, st());
        mode(mode_active);
        wr(`TWM_ADDR_RLD, 16'h0009);
        slow(5);
        mode(mode_save);
        slow(1);
        mode(mode_idle);
        slow(1);
        chk("low power", 16'h0202, st());
        mode(mode_halt);
        slow(2);
        chk("halt", 16'h0202, st());
        mode(mode_active);
        slow(1);
        chk("resume", 16'h0201, st());
    endtask
    // preset 1 gives an underflow every second tick after the restart reload
    task automatic t_uflow;
        do_reset;
        wr(`TWM_ADDR_T0, 16'h0001);
        wr(`TWM_ADDR_RLD, 16'h0003);
        wr(`TWM_ADDR_CSR, 16'h0005);
        slow(4);
        chk("underflow clock", 16'h0201, st());
        chk("underflow pulse", 16'h0001, {15'h0, timer0_underflow_pulse});
        rd(`TWM_ADDR_CSR);
        chk("count flag", 16'h0006, got);
        rd(`TWM_ADDR_CSR);
        chk("flag cleared", 16'h0004, got);
        slow(1);
        chk("pulse end", 16'h0000, {15'h0, timer0_underflow_pulse});
        chk("no edge", 16'h0201, st());
    endtask
    ////////////////////////////////////////
    initial begin
        do_reset;
        t_reset;
        t_div;
        t_reload;
        t_match;
        t_lock;
        t_modes;
        t_uflow;
        wrap_up;
    end
    initial begin
        #1000000;
        fail_count++;
        wrap_up;
    end
endmodule

// ### verification/twm_watchdog_sva.sv
`timescale 1ns/100ps
`include "twm_cfg.svh"
module twm_watchdog_chk (
    input wire logic               sys_clk,
    input wire logic               reset,
    input wire twm_pkg::twm_mode_t power_mode,
    input wire logic [23:0]        addr,
    input wire logic [15:0]        wr_data,
    input wire logic               wr_strobe,
    input wire logic               rd_strobe,
    input wire logic [15:0]        rd_data,
    input wire logic               prescaled_tick,
    input wire logic               timer0_underflow_pulse,
    input wire logic               wd_running,
    input wire logic [7:0]         wd_count,
    input wire logic               wd_error_reset
);
    import twm_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // lock bits as seen on the bus, so a start refused by a lock is not flagged
    logic                          cfg_locked;
    logic                          rld_locked;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cfg_locked <= 1'b0;
            rld_locked <= 1'b0;
        end else if (wr_strobe && addr == `TWM_ADDR_CFG && power_mode == mode_active && !cfg_locked) begin
            cfg_locked <= wr_data[`TWM_CFG_LOCK_CFG];
            rld_locked <= rld_locked | wr_data[`TWM_CFG_LOCK_RLD];
        end
    end
    ////////////////////////////////////////
    AST_NO_STOP: assert property (wd_running |=> wd_running)
        else $error("watchdog stopped");
    AST_IDLE_FROZEN: assert property (!wd_running |=> wd_running || $stable(wd_count))
        else $error("stopped watchdog moved");
    AST_STEP_ONE: assert property (wd_running && !wr_strobe |=> wd_error_reset
        || wd_count == $past(wd_count) || wd_count == $past(wd_count) - 8'h01)
        else $error("watchdog step not one");
    AST_START_LOAD: assert property (wr_strobe && addr == `TWM_ADDR_RLD && !rld_locked
        && power_mode == mode_active && !wd_running
        |=> wd_running && {8'h00, wd_count} == ($past(wr_data) & 16'h00FF))
        else $error("start did not load count");
    // service in the same cycle reloads the count but still raises the error, so only quiet cycles count
    AST_LATE: assert property (wd_running && wd_count == 8'h01 && !wr_strobe ##1
        wd_count == 8'h00 |-> ##[0:1] wd_error_reset)
        else $error("late service not flagged");
    AST_ERR_STICKY: assert property (wd_error_reset |=> wd_error_reset)
        else $error("error request dropped");
    AST_TICK_PULSE: assert property (prescaled_tick |=> !prescaled_tick)
        else $error("tick longer than one cycle");
    AST_HALT_STILL: assert property (power_mode == mode_halt ##1 power_mode == mode_halt
        |-> !prescaled_tick && !$rose(timer0_underflow_pulse))
        else $error("activity in halt");
    AST_UF_ON_TICK: assert property ($changed(timer0_underflow_pulse)
        |-> prescaled_tick || $past(prescaled_tick))
        else $error("underflow edge off tick");
    AST_RD_IDLE: assert property (!(rd_strobe && power_mode == mode_active)
        |=> rd_data == 16'h0000)
        else $error("read data without access");
endmodule
////////////////////////////////////////
bind twm_watchdog twm_watchdog_chk chk_u (.sys_clk, .reset, .power_mode, .addr, .wr_data,
    .wr_strobe, .rd_strobe, .rd_data, .prescaled_tick, .timer0_underflow_pulse, .wd_running,
    .wd_count, .wd_error_reset);
